// File: logic/btag_branch_target.v
// Next-instruction address generation: sequential, relative, immediate,
// table-indirect and register-indirect. Assumes the decoder raises step for one
// cycle per executed instruction, and, for table calls, first fetches the entry
// itself via tbl_addr and presents it on tbl_data with tbl_valid.
// A step that lands during a table wait is dropped with no indication.
`timescale 1ns/1ns
`include "btag_defs.vh"
module btag_branch_target #(
  parameter AW = 16
) (
  input wire clock,
  input wire rst_n,
  input wire step,
  input wire [4:0] mode,
  input wire [2:0] instr_len,
  input wire [7:0] branch_displacement,
  input wire [AW-1:0] imm_target,
  input wire [7:0] instr_code,
  input wire [AW-1:0] tbl_data,
  input wire tbl_valid,
  input wire [AW-1:0] accumulator_pair,
  output reg [AW-1:0] tbl_addr,
  output wire busy,
  output reg [AW-1:0] pc,
  output reg pc_loaded
);
  // One-hot states for the table fetch wait
  localparam ST_IDLE = 2'h1;
  localparam ST_TBL = 2'h2;

  // Next values, decoded request and derived addresses
  reg [1:0] state;
  reg [1:0] next_state;
  reg [AW-1:0] next_pc;
  reg next_loaded;
  reg [AW-1:0] next_tbl_addr;
  wire idle;
  wire take;
  wire sel_rel;
  wire sel_imm;
  wire sel_tbl;
  wire sel_reg;
  wire branch_load;
  wire [AW-1:0] seq_pc;
  wire [AW-1:0] disp_ext;
  wire [AW-1:0] rel_pc;
  wire [AW-1:0] entry_addr;

  // Modular add; the truncation is what makes the counter wrap
  function [AW-1:0] btag_add;
    input [AW-1:0] a;
    input [AW-1:0] b;
    begin
      btag_add = a + b;
    end
  endfunction

  // Two's complement widening of the displacement
  function [AW-1:0] btag_sext;
    input [7:0] d;
    begin
      btag_sext = {{(AW-8){d[7]}}, d};
    end
  endfunction

  // Byte address of a table entry; each entry is one 16-bit word
  function [AW-1:0] btag_entry;
    input [7:0] code;
    begin
      btag_entry = `BTAG_TBL_BASE | {{(AW-6){1'h0}}, code[`BTAG_SEL_MSB:`BTAG_SEL_LSB], 1'h0};
    end
  endfunction

  // Mode match against one one-hot code
  function btag_mode_is;
    input [4:0] m;
    input [4:0] code;
    begin
      btag_mode_is = (m == code);
    end
  endfunction

  // Requests count only while idle; a step during the table wait is lost
  assign idle = (state == ST_IDLE);
  assign take = step & idle;
  assign busy = (state == ST_TBL);

  // Mode decode shared by the load flag, wait state and table address
  assign sel_rel = btag_mode_is(mode, `BTAG_MODE_REL);
  assign sel_imm = btag_mode_is(mode, `BTAG_MODE_IMM);
  assign sel_tbl = btag_mode_is(mode, `BTAG_MODE_TBL);
  assign sel_reg = btag_mode_is(mode, `BTAG_MODE_REG);
  assign branch_load = sel_rel | sel_imm | sel_reg;

  // Start of the following instruction, shared by sequential and relative paths
  assign seq_pc = btag_add(pc, {{(AW-3){1'h0}}, instr_len});
  // Backward branches depend on the sign extension
  assign disp_ext = btag_sext(branch_displacement);
  assign rel_pc = btag_add(seq_pc, disp_ext);
  // Entry address from opcode bits 5:1
  assign entry_addr = btag_entry(instr_code);

  // Table wait entry and exit
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take && sel_tbl) begin
          next_state = ST_TBL;
        end
      end
      ST_TBL: begin
        if (tbl_valid) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Next address; carries out of bit 15 are simply lost
  always @* begin
    next_pc = pc;
    case (state)
      ST_IDLE: begin
        if (take) begin
          case (mode)
            `BTAG_MODE_SEQ: begin
              next_pc = seq_pc;
            end
            `BTAG_MODE_REL: begin
              next_pc = rel_pc;
            end
            `BTAG_MODE_IMM: begin
              next_pc = imm_target;
            end
            `BTAG_MODE_TBL: begin
              next_pc = pc; // Held until the table word arrives
            end
            `BTAG_MODE_REG: begin
              next_pc = accumulator_pair;
            end
            default: begin
              next_pc = seq_pc; // Unknown code taken as a plain step
            end
          endcase
        end
      end
      ST_TBL: begin
        // Steps are ignored until the table word arrives
        if (tbl_valid) begin
          next_pc = tbl_data;
        end
      end
      default: begin
        next_pc = pc;
      end
    endcase
  end

  // Load pulse for every branch that replaces the counter
  always @* begin
    next_loaded = 1'h0;
    case (state)
      ST_IDLE: begin
        next_loaded = take & branch_load;
      end
      ST_TBL: begin
        next_loaded = tbl_valid;
      end
      default: begin
        next_loaded = 1'h0;
      end
    endcase
  end

  // Entry address latched at the table step, so the decoder may move on
  always @* begin
    next_tbl_addr = tbl_addr;
    if (take && sel_tbl) begin
      next_tbl_addr = entry_addr;
    end
  end

  // Program counter
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc <= `BTAG_PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // Table wait state
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Load pulse register
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_loaded <= 1'h0;
    end else begin
      pc_loaded <= next_loaded;
    end
  end

  // Table entry address, reset to the table base, then holding the last entry address
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tbl_addr <= `BTAG_TBL_BASE;
    end else begin
      tbl_addr <= next_tbl_addr;
    end
  end

endmodule // btag_branch_target

// File: include/btag_defs.vh
// Constants for the branch target address generator of the core.
// Assumes the decoder presents one instruction per step, synchronous to clock.
// What this block does
// - With no branch, the counter advances by the fetched instruction's byte count.
// - Relative target is displacement plus start address of the following instruction.
// - Displacement is signed, bit 7 sign, sign-extended, reach -128 to +127.
// - Relative mode serves the short jump and every taken conditional branch.
// - Immediate mode loads the absolute target from the instruction into the counter.
// - Immediate targets reach the whole 64 KB space, no page limit.
// - Table call reads target from table 40H-7FH, entry from code bits 1-5.
// - Register-indirect jump loads the counter from the accumulator pair.
`ifndef BTAG_DEFS_VH
`define BTAG_DEFS_VH
`define BTAG_PC_RESET 16'h0000
`define BTAG_MODE_SEQ 5'h01
`define BTAG_MODE_REL 5'h02
`define BTAG_MODE_IMM 5'h04
`define BTAG_MODE_TBL 5'h08
`define BTAG_MODE_REG 5'h10
`define BTAG_TBL_BASE 16'h0040
`define BTAG_SEL_LSB 1
`define BTAG_SEL_MSB 5
`endif

// File: bench/btag_checker.sv
// Checker for the next-PC block, sees only its ports.
// Assumes the decoder pulses step only while the block is not busy.
`timescale 1ns/1ns
module btag_checker(input wire clock,rst_n,step,tbl_valid,busy,pc_loaded,input wire [4:0] mode,
 input wire [2:0] instr_len,input wire [7:0] branch_displacement,instr_code,
 input wire [15:0] imm_target,tbl_data,accumulator_pair,tbl_addr,pc);
default clocking @(posedge clock); endclocking
default disable iff (!rst_n);
// Accepted request and relative sum, wrap kept by width
wire go=step&&!busy;
wire [15:0] rel=pc+instr_len+{{8{branch_displacement[7]}},branch_displacement};
property p_seq; go&&mode==5'h01 |=> pc==$past(pc)+$past(instr_len)&&!pc_loaded; endproperty
a_seq: assert property(p_seq) else $error("sequential step wrong");
property p_rel; go&&mode==5'h02 |=> pc==$past(rel); endproperty
a_rel: assert property(p_rel) else $error("relative target wrong");
property p_rld; go&&mode==5'h02 |=> pc_loaded; endproperty
a_rld: assert property(p_rld) else $error("relative branch not loaded");
property p_nld; !(go&&(mode==5'h02||mode==5'h04||mode==5'h10))&&!(busy&&tbl_valid) |=> !pc_loaded; endproperty
a_nld: assert property(p_nld) else $error("load pulse without branch");
property p_tgo; go&&mode==5'h08 |=> busy&&$stable(pc)&&!pc_loaded; endproperty
a_tgo: assert property(p_tgo) else $error("table step did not wait");
property p_imm; go&&mode==5'h04 |=> pc==$past(imm_target)&&pc_loaded; endproperty
a_imm: assert property(p_imm) else $error("immediate target wrong");
property p_reg; go&&mode==5'h10 |=> pc==$past(accumulator_pair)&&pc_loaded; endproperty
a_reg: assert property(p_reg) else $error("register jump wrong");
property p_tad; busy |-> tbl_addr=={9'h000,1'b1,instr_code[5:1],1'b0}; endproperty
a_tad: assert property(p_tad) else $error("table address wrong");
property p_tld; busy&&tbl_valid |=> pc==$past(tbl_data)&&!busy&&pc_loaded; endproperty
a_tld: assert property(p_tld) else $error("table load wrong");
property p_hld; busy&&!tbl_valid |=> $stable(pc)&&!pc_loaded; endproperty
a_hld: assert property(p_hld) else $error("pc moved while waiting");
endmodule // btag_checker
bind btag_branch_target btag_checker i_chk(.*);

// File: bench/btag_table.sv
// Table memory model: answers a table fetch after lag cycles.
// Assumes busy marks the wait; data is scrambled when not valid.
`timescale 1ns/1ns
module btag_table(input wire clock,busy,input wire [3:0] lag,input wire [15:0] tbl_addr,
 output reg tbl_valid=0,output reg [15:0] tbl_data=0);
reg [3:0] n=0;
// Slow or prompt answer, word derived from the entry address
always @(negedge clock) begin
  n<=busy&&!tbl_valid?n+1:0;
  tbl_valid<=busy&&!tbl_valid&&n==lag;
  tbl_data<=busy&&!tbl_valid&&n==lag?tbl_addr*16'h0123:~tbl_data;
end
endmodule // btag_table

// File: bench/btag_branch_target_test.sv
// Bench: random instruction stream against a reference next PC.
// Assumes the table model answers every fetch.
`timescale 1ns/1ns
module btag_branch_target_test;
reg clock=0,rst_n=0,step=0; reg [4:0] mode=1; reg [2:0] instr_len=0; reg [7:0] branch_displacement=0,instr_code=0;
reg [15:0] imm_target=0,accumulator_pair=0,exp=0; reg [3:0] lag=0; wire tbl_valid,busy,pc_loaded;
wire [15:0] tbl_data,tbl_addr,pc; integer bad_count=0,n_compared=0,seed=32'h61ed4e91,i,w;
btag_branch_target i_dut(.clock(clock),.rst_n(rst_n),.step(step),.mode(mode),.instr_len(instr_len),
 .branch_displacement(branch_displacement),.imm_target(imm_target),.instr_code(instr_code),.tbl_data(tbl_data),
 .tbl_valid(tbl_valid),.accumulator_pair(accumulator_pair),.tbl_addr(tbl_addr),.busy(busy),.pc(pc),.pc_loaded(pc_loaded));
btag_table i_tbl(.clock(clock),.busy(busy),.lag(lag),.tbl_addr(tbl_addr),.tbl_valid(tbl_valid),.tbl_data(tbl_data));
initial forever #50 clock=~clock;
task check(input string what,input [15:0] seen,input [15:0] want); begin
  n_compared=n_compared+1;
  if (seen!==want) begin
    bad_count=bad_count+1;
    $display("ERROR %s exp %h seen %h",what,want,seen);
  end
end endtask
task report_and_stop; begin
  $display("compared %0d bad %0d",n_compared,bad_count);
  if (bad_count==0&&n_compared>0) $display("ALL CHECKS OK");
  else $display("CHECKS NOT OK");
  $finish;
end endtask
// Reference next PC; 16-bit result drops carries
function [15:0] next_pc(input [4:0] m); begin
  case (m)
    5'h02: next_pc=exp+instr_len+{{8{branch_displacement[7]}},branch_displacement};
    5'h04: next_pc=imm_target;
    5'h08: next_pc={9'h000,1'b1,instr_code[5:1],1'b0}*16'h0123;
    5'h10: next_pc=accumulator_pair;
    default: next_pc=exp+instr_len;
  endcase
end endfunction
// Watchdog well past the longest expected run
initial begin #1000000; bad_count=bad_count+1; report_and_stop; end
initial begin
  repeat (3) @(negedge clock);
  rst_n=1;
  check("pc",pc,16'h0000);
  check("flags",{busy,pc_loaded},16'h0000);
  for (i=0;i<400;i=i+1) begin
    // Mid-run reset, taken with step possibly still high
    if (i==200) begin
      rst_n=0;
      @(negedge clock);
      check("pc",pc,16'h0000);
      check("flags",{busy,pc_loaded},16'h0000);
      rst_n=1;
      exp=16'h0000;
    end
    mode=(i%29==7)?5'h03:5'h01<<({$random(seed)}%5); // Stray code counts as a plain step
    instr_len={$random(seed)}%4+1;
    branch_displacement=i[0]?$random(seed):(i[1]?8'h80:8'h7f); // Both reach limits
    imm_target=i%3?$random(seed):16'hfffe; // Wrap corner
    {instr_code,accumulator_pair,lag}={$random(seed),$random(seed)};
    lag=lag%8;
    exp=next_pc(mode);
    step=1;
    @(negedge clock);
    if (busy) step=0; // Kept high for back-to-back steps, never dropped and raised at once
    w=0;
    while (busy&&w<20) begin
      @(negedge clock);
      w=w+1;
    end
    check("pc",pc,exp);
    check("loaded",pc_loaded,mode!=5'h01&&mode!=5'h03);
    check("busy",busy,16'h0000);
  end
  step=0;
  report_and_stop;
end
endmodule // btag_branch_target_test
